// [rtl/serial_output_pkg.sv]
`default_nettype none
package serial_output_pkg;
    // Register offsets
    localparam logic [7:0] OFS_FUSE_MAP_LOAD       = 8'h13;
    localparam logic [7:0] OFS_PATTERN_VALUE_LOW   = 8'h14;
    localparam logic [7:0] OFS_PATTERN_VALUE_MID   = 8'h15;
    localparam logic [7:0] OFS_PATTERN_SELECT_HIGH = 8'h16;
    localparam logic [7:0] OFS_INPUT_CLOCK_BUFFER  = 8'h18;
    localparam logic [7:0] OFS_FRAME_CLOCK_CONFIG  = 8'h19;
    // Field positions
    localparam int POS_FUSE_LOAD      = 0;
    localparam int POS_SECOND_SEL_LO  = 5;
    localparam int POS_FIRST_SEL_LO   = 2;
    localparam int POS_BUF_ON         = 4;
    localparam int POS_FC_ORIGIN      = 7;
    localparam int POS_FC_HALVING     = 4;
    localparam int POS_FC_OUTPUT_ON   = 1;
    localparam int POS_FC_STRETCH     = 0;
    // Writable masks, reserved bits ignored
    localparam logic [7:0] MASK_FUSE  = 8'h01;
    localparam logic [7:0] MASK_BUF   = 8'h10;
    localparam logic [7:0] MASK_FC    = 8'h93;
    // Reset values
    localparam logic [7:0] RST_FUSE   = 8'h00;
    localparam logic [7:0] RST_LOW    = 8'h00;
    localparam logic [7:0] RST_MID    = 8'h00;
    localparam logic [7:0] RST_HIGH   = 8'h00;
    localparam logic [7:0] RST_BUF    = 8'h10;
    localparam logic [7:0] RST_FC     = 8'h02;
    // Widths and FIFO depth
    localparam int PATTERN_W = 18;
    localparam int NATIVE_W  = 16;
    localparam int FIFO_DEPTH = 32;
    // Pattern selector codes
    typedef enum logic [2:0] {
        PAT_NORMAL   = 3'h0,
        PAT_RAMP     = 3'h2,
        PAT_CONSTANT = 3'h3
    } pattern_sel_t;
    // Frame clock states, Gray along the usual path
    typedef enum logic [1:0] {
        FC_IDLE = 2'b00,
        FC_HIGH = 2'b01,
        FC_LOW  = 2'b11
    } fc_state_t;
endpackage
`default_nettype wire

// [rtl/sample_stream_if.sv]
`default_nettype none
interface sample_stream_if #(parameter int W = 36);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// [rtl/sample_fifo.sv]
`default_nettype none
module sample_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sample_stream_if.sink   in_s,
    sample_stream_if.source out_s
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    room;
    } fifo_state_t;
    fifo_state_t s_q, s_d;
    logic push, pop;
    assign in_s.ready  = s_q.room;
    assign out_s.valid = (s_q.cnt != '0);
    assign out_s.data  = s_q.mem[s_q.rd];
    assign push = in_s.valid && in_s.ready;
    assign pop  = out_s.valid && out_s.ready;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_s.data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) s_d.rd = s_q.rd + 1'b1;
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Ready comes from a flop, judged on the count after this edge
        s_d.room = (s_d.cnt != (AW+1)'(DEPTH));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) s_q <= '0;
        else s_q <= s_d;
    end
    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// [rtl/serial_output_config.sv]
`default_nettype none
// Function
// - A fuse-map load returns all configuration registers except the fuse-map load register to reset values.
// - Constant pattern outputs the 18-bit custom value, MSB aligned.
// - Second channel selector bits 7-5: 000 normal, 010 ramp, 011 constant.
// - First channel selector bits 4-2 decodes the same way.
// - Patterns inserted before bit mapper at the 18-bit output width; native samples MSB aligned.
// - Frame clock origin zero selects converter core frame timing.
// - Frame clock output driven only while its enable bit is one.
// - Stretch bit lengthens frame clock to span both channels' words.
module serial_output_config
    import serial_output_pkg::*;
#(
    parameter int NW = serial_output_pkg::NATIVE_W
) (
    input  wire logic                                    clk,
    input  wire logic                                    reset_n,
    input  wire logic                                    reg_wr,
    input  wire logic                                    reg_rd,
    input  wire logic [7:0]                              reg_addr,
    input  wire logic [7:0]                              reg_wdata,
    output var  logic [7:0]                              reg_rdata,
    input  wire logic                                    external_data_clock_in,
    input  wire logic                                    sample_valid,
    output var  logic                                    sample_ready,
    input  wire logic [NW-1:0]                           sample_first,
    input  wire logic [NW-1:0]                           sample_second,
    input  wire logic                                    core_frame_strobe,
    input  wire logic                                    ddc_frame_strobe,
    output var  logic                                    word_valid,
    output var  logic [serial_output_pkg::PATTERN_W-1:0] word_first,
    output var  logic [serial_output_pkg::PATTERN_W-1:0] word_second,
    output var  logic                                    frame_clock,
    output var  logic                                    frame_clock_oe_n,
    output var  logic                                    frame_clock_halving,
    output var  logic                                    data_clock_input_buffer_on,
    output var  logic                                    fuse_map_load_strobe
);
    import serial_output_pkg::*;

    localparam int DW = 2 * PATTERN_W;

    typedef struct packed {
        logic [1:0]           rst_sync;
        logic [7:0]           fuse;
        logic [7:0]           low;
        logic [7:0]           mid;
        logic [7:0]           high;
        logic [7:0]           buf_ctl;
        logic [7:0]           fc;
        logic [7:0]           rdata;
        logic [2:0]           dclk_sync;
        logic [PATTERN_W-1:0] ramp_first;
        logic [PATTERN_W-1:0] ramp_second;
        fc_state_t            fc_state;
        logic                 fc_phase;
        logic                 frame;
        logic                 frame_oe_n;
        logic                 halving;
        logic                 buf_on;
        logic                 load_pulse;
        logic                 wvalid;
        logic [DW-1:0]        wdata;
    } cfg_state_t;

    cfg_state_t s_q, s_d;
    logic       rst_n;
    assign rst_n = s_q.rst_sync[1];

    sample_stream_if #(.W(DW)) fifo_in ();
    sample_stream_if #(.W(DW)) fifo_out ();

    sample_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (fifo_in),
        .out_s (fifo_out)
    );

    // Native sample widened to output width, MSB aligned
    function automatic logic [PATTERN_W-1:0] native_msb(input logic [NW-1:0] v);
        native_msb = {v, {(PATTERN_W-NW){1'b0}}};
    endfunction

    function automatic logic [PATTERN_W-1:0] pick(
        input logic [2:0]           sel,
        input logic [NW-1:0]        smp,
        input logic [PATTERN_W-1:0] ramp,
        input logic [PATTERN_W-1:0] pat
    );
        case (sel)
            PAT_RAMP:     pick = ramp;
            PAT_CONSTANT: pick = pat;
            default:      pick = native_msb(smp);
        endcase
    endfunction

    logic [PATTERN_W-1:0] pat_value;
    logic [2:0]           sel_first, sel_second;
    logic                 dclk_rise, strobe_in, accept;
    assign pat_value  = {s_q.high[1:0], s_q.mid, s_q.low};
    assign sel_second = s_q.high[POS_SECOND_SEL_LO +: 3];
    assign sel_first  = s_q.high[POS_FIRST_SEL_LO +: 3];
    assign dclk_rise  = s_q.dclk_sync[1] && !s_q.dclk_sync[2];
    assign accept     = sample_valid && fifo_in.ready;
    assign strobe_in  = s_q.fc[POS_FC_ORIGIN] ? ddc_frame_strobe
                                              : core_frame_strobe;

    assign fifo_in.valid = sample_valid;
    assign fifo_in.data  = {pick(sel_second, sample_second, s_q.ramp_second, pat_value),
                            pick(sel_first, sample_first, s_q.ramp_first, pat_value)};
    assign fifo_out.ready = dclk_rise;

    always_comb begin
        s_d = s_q;
        s_d.rst_sync   = {s_q.rst_sync[0], 1'b1};
        s_d.dclk_sync  = {s_q.dclk_sync[1:0], external_data_clock_in};
        s_d.load_pulse = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                OFS_FUSE_MAP_LOAD: begin
                    s_d.fuse = reg_wdata & MASK_FUSE;
                    // Falling edge of the load bit applies the mapping
                    if (s_q.fuse[POS_FUSE_LOAD] && !reg_wdata[POS_FUSE_LOAD]) begin
                        s_d.load_pulse = 1'b1;
                    end
                end
                OFS_PATTERN_VALUE_LOW:   s_d.low  = reg_wdata;
                OFS_PATTERN_VALUE_MID:   s_d.mid  = reg_wdata;
                OFS_PATTERN_SELECT_HIGH: s_d.high = reg_wdata;
                OFS_INPUT_CLOCK_BUFFER:  s_d.buf_ctl = reg_wdata & MASK_BUF;
                OFS_FRAME_CLOCK_CONFIG:  s_d.fc = reg_wdata & MASK_FC;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_FUSE_MAP_LOAD:       s_d.rdata = s_q.fuse;
                OFS_PATTERN_VALUE_LOW:   s_d.rdata = s_q.low;
                OFS_PATTERN_VALUE_MID:   s_d.rdata = s_q.mid;
                OFS_PATTERN_SELECT_HIGH: s_d.rdata = s_q.high;
                OFS_INPUT_CLOCK_BUFFER:  s_d.rdata = s_q.buf_ctl;
                OFS_FRAME_CLOCK_CONFIG:  s_d.rdata = s_q.fc;
                default:                 s_d.rdata = 8'h00;
            endcase
        end
        // Load discards earlier writes, keeping the load bit itself
        if (s_q.load_pulse) begin
            s_d.low     = RST_LOW;
            s_d.mid     = RST_MID;
            s_d.high    = RST_HIGH;
            s_d.buf_ctl = RST_BUF;
            s_d.fc      = RST_FC;
        end
        if (accept) begin
            s_d.ramp_first  = s_q.ramp_first + pat_value;
            s_d.ramp_second = s_q.ramp_second + pat_value;
        end
        s_d.wvalid = fifo_out.valid && dclk_rise;
        if (s_d.wvalid) s_d.wdata = fifo_out.data;
        // Frame clock: high one strobe period, low next; stretch covers both words
        case (s_q.fc_state)
            FC_IDLE: if (strobe_in) begin
                s_d.fc_state = FC_HIGH;
                s_d.fc_phase = 1'b0;
            end
            FC_HIGH: if (strobe_in) begin
                if (s_q.fc[POS_FC_STRETCH] && !s_q.fc_phase) begin
                    s_d.fc_phase = 1'b1;
                end else begin
                    s_d.fc_state = FC_LOW;
                end
            end
            FC_LOW: if (strobe_in) begin
                s_d.fc_state = FC_HIGH;
                s_d.fc_phase = 1'b0;
            end
            default: s_d.fc_state = FC_IDLE;
        endcase
        s_d.frame      = s_q.fc[POS_FC_OUTPUT_ON] && (s_q.fc_state == FC_HIGH);
        s_d.frame_oe_n = !s_q.fc[POS_FC_OUTPUT_ON];
        s_d.halving    = s_q.fc[POS_FC_HALVING];
        s_d.buf_on     = s_q.buf_ctl[POS_BUF_ON];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q            <= '0;
            s_q.fuse       <= RST_FUSE;
            s_q.buf_ctl    <= RST_BUF;
            s_q.fc         <= RST_FC;
            s_q.fc_state   <= FC_IDLE;
            s_q.frame_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_ready               = fifo_in.ready;
    assign reg_rdata                  = s_q.rdata;
    assign word_valid                 = s_q.wvalid;
    assign word_first                 = s_q.wdata[PATTERN_W-1:0];
    assign word_second                = s_q.wdata[DW-1:PATTERN_W];
    assign frame_clock                = s_q.frame;
    assign frame_clock_oe_n           = s_q.frame_oe_n;
    assign frame_clock_halving        = s_q.halving;
    assign data_clock_input_buffer_on = s_q.buf_on;
    assign fuse_map_load_strobe       = s_q.load_pulse;

    a_load_resets_fc: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.load_pulse |=> s_q.fc == RST_FC) else $error("load did not reset");
    a_const_pattern: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && sel_first == PAT_CONSTANT) |-> fifo_in.data[PATTERN_W-1:0] == pat_value)
        else $error("constant pattern wrong");
    a_second_normal: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && sel_second == PAT_NORMAL)
        |-> fifo_in.data[DW-1:PATTERN_W] == native_msb(sample_second))
        else $error("second channel normal wrong");
    a_first_ramp: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && sel_first == PAT_RAMP) |=>
        s_q.ramp_first == $past(s_q.ramp_first) + $past(pat_value))
        else $error("ramp step wrong");
    a_native_lsbs: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && sel_first == PAT_NORMAL)
        |-> fifo_in.data[PATTERN_W-NW-1:0] == '0) else $error("not msb aligned");
    a_frame_off: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.fc[POS_FC_OUTPUT_ON] |=> !frame_clock && frame_clock_oe_n)
        else $error("frame clock driven while off");
    a_reserved_fc: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.fc & ~MASK_FC) == 8'h00) else $error("reserved bit stored");
    a_stretch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.fc[POS_FC_STRETCH] && s_q.fc_state == FC_HIGH && !s_q.fc_phase && strobe_in)
        |=> s_q.fc_state == FC_HIGH) else $error("stretch not held");
    c_load: cover property (@(posedge clk) s_q.load_pulse);
    c_const: cover property (@(posedge clk) accept && sel_first == PAT_CONSTANT);
    c_word: cover property (@(posedge clk) word_valid);
    c_full: cover property (@(posedge clk) disable iff (!rst_n) !sample_ready);
endmodule
`default_nettype wire

// [tb/word_link_partner.sv]
`default_nettype none
module word_link_partner (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        word_valid,
    input  wire logic [17:0] word_first,
    input  wire logic [17:0] word_second,
    output var  logic        link_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] got_first[$];
    logic [17:0] got_second[$];
    // Link clock stands low between bursts, phase offset from clk
    initial begin
        link_clk = 1'b0;
        #3;
        forever begin
            wait (run);
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
    end
    always @(posedge clk) begin
        if (word_valid === 1'b1) begin
            got_first.push_back(word_first);
            got_second.push_back(word_second);
        end
    end
endmodule
`default_nettype wire

// [tb/serial_output_config_test_pattern_tb.sv]
`default_nettype none
module serial_output_config_test_pattern_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_output_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        run = 1'b0, sample_valid = 1'b0, core_s = 1'b0, ddc_s = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [15:0] sf = 16'h0000, ss = 16'h0000, v;
    logic        link_clk, sample_ready, word_valid, frame_clock, fc_oe_n;
    logic        halving, buf_on, load_strobe;
    logic [17:0] wf, ws;
    int          n_mismatch = 0, num_checks = 0;
    logic [7:0]  ofs [6] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19};
    logic [7:0]  rst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02};
    always #4 clk = ~clk;
    serial_output_config dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .external_data_clock_in(link_clk), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_first(sf), .sample_second(ss),
        .core_frame_strobe(core_s), .ddc_frame_strobe(ddc_s), .word_valid(word_valid),
        .word_first(wf), .word_second(ws), .frame_clock(frame_clock),
        .frame_clock_oe_n(fc_oe_n), .frame_clock_halving(halving),
        .data_clock_input_buffer_on(buf_on), .fuse_map_load_strobe(load_strobe));
    word_link_partner partner (.clk(clk), .run(run), .word_valid(word_valid),
        .word_first(wf), .word_second(ws), .link_clk(link_clk));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic fail(string m);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("register %h expected %h", got, exp));
    endtask
    task automatic chk_word(logic [17:0] got, logic [17:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
    endtask
    task automatic chk_bit(logic got, logic exp);
        num_checks++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, exp);
    endtask
    task automatic fuse_load();
        logic seen;
        wr(8'h13, 8'h01);
        wr(8'h13, 8'h00);
        seen = 1'b0;
        repeat (4) begin
            seen = seen | (load_strobe === 1'b1);
            @(negedge clk);
        end
        chk_bit(seen, 1'b1);
        chk_bit(load_strobe, 1'b0);
    endtask
    task automatic push(logic [15:0] f, logic [15:0] s);
        int i;
        @(negedge clk);
        for (i = 0; i < 100 && sample_ready !== 1'b1; i++) @(negedge clk);
        if (i == 100) begin
            fail("input stream stuck");
            end_of_test();
        end
        sample_valid = 1'b1;
        sf = f;
        ss = s;
        @(negedge clk);
        sample_valid = 1'b0;
    endtask
    task automatic drain(int n);
        int i;
        partner.got_first.delete();
        partner.got_second.delete();
        run = 1'b1;
        for (i = 0; i < 3000 && partner.got_first.size() < n; i++) @(negedge clk);
        run = 1'b0;
        if (i == 3000) begin
            fail("words missing");
            end_of_test();
        end
    endtask
    task automatic strobe(logic from_ddc, logic exp);
        @(negedge clk);
        core_s = !from_ddc;
        ddc_s = from_ddc;
        @(negedge clk);
        core_s = 1'b0;
        ddc_s = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit(frame_clock, exp);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        rd(8'h17, 8'h00);
        chk_bit(buf_on, 1'b1);
        chk_bit(fc_oe_n, 1'b0);
        fuse_load();
        wr(8'h18, 8'hFF);
        rd(8'h18, 8'h10);
        wr(8'h18, 8'h00);
        @(negedge clk);
        chk_bit(buf_on, 1'b0);
        wr(8'h19, 8'hFF);
        rd(8'h19, 8'h93);
        chk_bit(halving, 1'b1);
        wr(8'h19, 8'h02);
        strobe(1'b1, 1'b0);
        strobe(1'b0, 1'b1);
        strobe(1'b0, 1'b0);
        wr(8'h19, 8'h82);
        strobe(1'b0, 1'b0);
        strobe(1'b1, 1'b1);
        strobe(1'b1, 1'b0);
        wr(8'h19, 8'h83);
        strobe(1'b1, 1'b1);
        strobe(1'b1, 1'b1);
        strobe(1'b1, 1'b0);
        wr(8'h19, 8'h00);
        @(negedge clk);
        chk_bit(fc_oe_n, 1'b1);
        wr(8'h16, 8'hFF);
        wr(8'h13, 8'h01);
        rd(8'h16, 8'hFF);
        fuse_load();
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        // Unused selector codes, FIFO filled with link stalled
        wr(8'h16, 8'hE4);
        for (int i = 0; i < 32; i++) push(16'h1000 + 16'(i), 16'h8000 + 16'(i));
        @(negedge clk);
        chk_bit(sample_ready, 1'b0);
        drain(32);
        for (int i = 0; i < 32; i++) begin
            v = 16'h1000 + 16'(i);
            chk_word(partner.got_first[i], {v, 2'b00});
            v = 16'h8000 + 16'(i);
            chk_word(partner.got_second[i], {v, 2'b00});
        end
        wr(8'h14, 8'h34);
        wr(8'h15, 8'h12);
        wr(8'h16, 8'h6E);
        repeat (2) push(16'hAAAA, 16'h5555);
        drain(2);
        for (int i = 0; i < 2; i++) begin
            chk_word(partner.got_first[i], 18'h2_1234);
            chk_word(partner.got_second[i], 18'h2_1234);
        end
        wr(8'h14, 8'h04);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h48);
        repeat (3) push(16'h0F0F, 16'hF0F0);
        drain(3);
        for (int i = 1; i < 3; i++) begin
            chk_word(partner.got_first[i] - partner.got_first[i-1], 18'h0_0004);
            chk_word(partner.got_second[i] - partner.got_second[i-1], 18'h0_0004);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
